// [pkg/ccs_pkg.sv]
// Shared constants and types for the charger control and status register bank
package ccs_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] ADDR_SENSE_TIMEOUT_CONTROL   = 8'h11;
  localparam logic [7:0] ADDR_OUTPUT_PROTECT_CONTROL  = 8'h12;
  localparam logic [7:0] ADDR_BATTERY_BUS_FAULT_STAT  = 8'h13;
  localparam logic [7:0] ADDR_INPUT_CURRENT_FAULT_STAT = 8'h14;

  // Reset values
  localparam logic [7:0] SENSE_TIMEOUT_RST  = 8'h71;
  localparam logic [7:0] OUTPUT_PROTECT_RST = 8'h60;
  localparam logic [7:0] STATUS_RST         = 8'h00;

  // Field masks: soft reset keeps the soft-start field, role field is read-only
  localparam logic [7:0] SOFT_KEEP_MASK_11 = 8'h70;
  localparam logic [7:0] CTL12_WR_MASK     = 8'hFC;

  // Serial device address; the value is arbitrary
  localparam logic [6:0] I2C_DEV_ADDR = 7'h2A;

  // Switching frequency base codes, in units of 0.25 kHz
  localparam logic [11:0] FREQ_Q_187K5 = 12'h2EE;
  localparam logic [11:0] FREQ_Q_250K  = 12'h3E8;
  localparam logic [11:0] FREQ_Q_300K  = 12'h4B0;
  localparam logic [11:0] FREQ_Q_375K  = 12'h5DC;
  localparam logic [11:0] FREQ_Q_500K  = 12'h7D0;
  localparam logic [11:0] FREQ_Q_750K  = 12'hBB8;
  localparam logic [11:0] TRIM_DIVISOR = 12'h00A;

  // Frequency trim codes
  localparam logic [1:0] TRIM_NOMINAL = 2'h0;
  localparam logic [1:0] TRIM_UP      = 2'h1;
  localparam logic [1:0] TRIM_DOWN    = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_ADDR    = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_WR_BYTE = 3'h2,
    ST_WR_ACK  = 3'h6,
    ST_RD_BYTE = 3'h7,
    ST_RD_ACK  = 3'h5
  } ccs_state_e;

  typedef struct packed {
    logic       sense_resistor_sel;
    logic [2:0] softstart_limit;
    logic [1:0] undercurrent_deglitch_sel;
    logic [1:0] reserved;
  } ccs_ctl11_s;

  typedef struct packed {
    logic       out_overvolt_off;
    logic [1:0] out_overvolt_level;
    logic [1:0] switch_freq_trim;
    logic       reserved;
    logic [1:0] role_select;
  } ccs_ctl12_s;

  // Upper eight bits follow the battery/bus status register layout
  typedef struct packed {
    logic batt_overvolt_flag;
    logic batt_overvolt_alarm_flag;
    logic out_overvolt_flag;
    logic batt_overcurrent_flag;
    logic batt_overcurrent_alarm_flag;
    logic batt_undercurrent_alarm_flag;
    logic in_overvolt_flag;
    logic in_overvolt_alarm_flag;
    logic in_overcurrent_flag;
    logic in_overcurrent_alarm_flag;
    logic in_undercurrent_flag;
    logic in_reverse_current_flag;
    logic flying_cap_short_flag;
  } ccs_fault_s;

  typedef struct packed {
    logic        sense_resistor_sel;
    logic [2:0]  softstart_limit;
    logic [1:0]  undercurrent_deglitch_sel;
    logic        out_overvolt_off;
    logic [1:0]  out_overvolt_level;
    logic [1:0]  switch_freq_trim;
    logic [11:0] switch_freq_qkhz;
  } ccs_cfg_s;

  typedef struct packed {
    ccs_state_e  st;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        ptr_phase;
    logic        rw;
    logic        nack;
    logic        scl_prev;
    logic        sda_prev;
    logic        sda_oe;
    logic        sda_low;
    ccs_ctl11_s  ctl11;
    ccs_ctl12_s  ctl12;
    ccs_fault_s  fault;
    logic        fet_off;
    logic        chg_clr;
    logic        wd_restart;
    logic [11:0] freq;
  } ccs_regs_s;

endpackage : ccs_pkg

// [core/ccs_sync.sv]
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module ccs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset_n,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [2*W-1:0] stage_ff;
  logic [2*W-1:0] nxt_stage;

  // First stage feeds only the second stage
  always_comb begin
    nxt_stage = {stage_ff[W-1:0], d};
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage_ff <= '0;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  assign q = stage_ff[2*W-1:W];

endmodule : ccs_sync

// [core/charger_control_status_regs.sv]
// Charger control and status registers with serial two-wire register port
`timescale 1ns/1ps
module charger_control_status_regs (
  // Clock and power-on reset
  input  wire logic               clock,
  input  wire logic               reset_n,
  // Two-wire serial register port
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  // Analog comparators and role strap
  input  wire ccs_pkg::ccs_fault_s fault_in,
  input  wire logic [1:0]         role_strap,
  // Neighbouring control registers
  input  wire logic               soft_reg_reset,
  input  wire logic [2:0]         switch_freq_base,
  // Control outputs
  output ccs_pkg::ccs_cfg_s       cfg,
  output logic                    fet_off,
  output logic                    charge_enable_clear,
  output logic                    watchdog_restart
);
  import ccs_pkg::*;

  ccs_regs_s  r_ff;
  ccs_regs_s  nxt_r;
  logic [16:0] sync_q;
  logic       scl_s;
  logic       sda_s;
  logic [1:0] role_s;
  ccs_fault_s fault_s;
  logic       start_c;
  logic       stop_c;
  logic       rise_c;
  logic       fall_c;
  logic [7:0] rd_data;
  logic [7:0] stat13;
  logic [7:0] stat14;
  logic [11:0] base_q;
  logic [11:0] tenth_q;

  ccs_sync #(.W(17)) u_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .d       ({scl_in, sda_in, role_strap, fault_in}),
    .q       (sync_q)
  );

  assign {scl_s, sda_s, role_s, fault_s} = sync_q;

  // Bus conditions seen on synchronised lines
  // Synchronised lines leave reset low, so the first sample may look like an SCL rise;
  // idle ignores rises, and a START needs two high samples of SCL with SDA high on the first
  assign start_c = scl_s & r_ff.scl_prev & r_ff.sda_prev & ~sda_s;
  assign stop_c  = scl_s & r_ff.scl_prev & ~r_ff.sda_prev & sda_s;
  assign rise_c  = scl_s & ~r_ff.scl_prev;
  assign fall_c  = ~scl_s & r_ff.scl_prev;

  // Status views of the live fault levels
  assign stat13 = r_ff.fault[12:5];
  assign stat14 = {r_ff.fault.in_overcurrent_flag, r_ff.fault.in_overcurrent_alarm_flag,
                   r_ff.fault.in_undercurrent_flag, r_ff.fault.in_reverse_current_flag,
                   1'b0, r_ff.fault.flying_cap_short_flag, 2'b00};

  // Reads return the addressed byte; the pointer moves on as each byte is loaded
  always_comb begin
    case (r_ff.ptr)
      ADDR_SENSE_TIMEOUT_CONTROL:    rd_data = r_ff.ctl11;
      ADDR_OUTPUT_PROTECT_CONTROL:   rd_data = r_ff.ctl12;
      ADDR_BATTERY_BUS_FAULT_STAT:   rd_data = stat13;
      ADDR_INPUT_CURRENT_FAULT_STAT: rd_data = stat14;
      default:                       rd_data = STATUS_RST;
    endcase
  end

  // Nominal frequency from the base code; unused codes fall back to 500 kHz
  always_comb begin
    case (switch_freq_base)
      3'h0:    base_q = FREQ_Q_187K5;
      3'h1:    base_q = FREQ_Q_250K;
      3'h2:    base_q = FREQ_Q_300K;
      3'h3:    base_q = FREQ_Q_375K;
      3'h5:    base_q = FREQ_Q_750K;
      default: base_q = FREQ_Q_500K;
    endcase
    // Floor division keeps the trimmed value a whole count of 0.25 kHz steps
    tenth_q = base_q / TRIM_DIVISOR;
  end

  always_comb begin
    nxt_r            = r_ff;
    nxt_r.scl_prev   = scl_s;
    nxt_r.sda_prev   = sda_s;
    nxt_r.sda_low    = 1'b0;
    nxt_r.fault      = fault_s;
    nxt_r.ctl12.role_select = role_s;
    nxt_r.wd_restart = soft_reg_reset;

    // Protection acts while the comparator is high and not disabled
    nxt_r.fet_off = fault_s.out_overvolt_flag & ~r_ff.ctl12.out_overvolt_off;
    nxt_r.chg_clr = nxt_r.fet_off & ~r_ff.fet_off;

    case (r_ff.ctl12.switch_freq_trim)
      TRIM_UP:   nxt_r.freq = base_q + tenth_q;
      TRIM_DOWN: nxt_r.freq = base_q - tenth_q;
      default:   nxt_r.freq = base_q;
    endcase

    if (start_c) begin
      nxt_r.st        = ST_ADDR;
      nxt_r.bit_cnt   = 4'h0;
      nxt_r.ptr_phase = 1'b1;
      nxt_r.sda_oe    = 1'b0;
    end else if (stop_c) begin
      nxt_r.st     = ST_IDLE;
      nxt_r.sda_oe = 1'b0;
    end else begin
      case (r_ff.st)
        ST_IDLE: begin
          nxt_r.sda_oe = 1'b0;
        end
        ST_ADDR: begin
          if (rise_c) begin
            nxt_r.shreg   = {r_ff.shreg[6:0], sda_s};
            nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
          end else if (fall_c && r_ff.bit_cnt == 4'h8) begin
            if (r_ff.shreg[7:1] == I2C_DEV_ADDR) begin
              nxt_r.rw     = r_ff.shreg[0];
              nxt_r.sda_oe = 1'b1;
              nxt_r.st     = ST_ADDR_ACK;
            end else begin
              nxt_r.st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (fall_c) begin
            nxt_r.bit_cnt = 4'h0;
            if (r_ff.rw) begin
              nxt_r.shreg  = rd_data;
              nxt_r.sda_oe = ~rd_data[7];
              nxt_r.ptr    = r_ff.ptr + 8'h01;
              nxt_r.st     = ST_RD_BYTE;
            end else begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.st     = ST_WR_BYTE;
            end
          end
        end
        ST_WR_BYTE: begin
          if (rise_c) begin
            nxt_r.shreg   = {r_ff.shreg[6:0], sda_s};
            nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
          end else if (fall_c && r_ff.bit_cnt == 4'h8) begin
            nxt_r.sda_oe = 1'b1;
            nxt_r.st     = ST_WR_ACK;
            if (r_ff.ptr_phase) begin
              nxt_r.ptr       = r_ff.shreg;
              nxt_r.ptr_phase = 1'b0;
            end else begin
              nxt_r.ptr = r_ff.ptr + 8'h01;
              if (r_ff.ptr == ADDR_SENSE_TIMEOUT_CONTROL) begin
                nxt_r.ctl11 = ccs_ctl11_s'(r_ff.shreg);
              end else if (r_ff.ptr == ADDR_OUTPUT_PROTECT_CONTROL) begin
                nxt_r.ctl12 = ccs_ctl12_s'((r_ff.shreg & CTL12_WR_MASK) |
                                           {6'h00, role_s});
              end
              // Status and unmapped offsets drop the data
            end
          end
        end
        ST_WR_ACK: begin
          if (fall_c) begin
            nxt_r.sda_oe  = 1'b0;
            nxt_r.bit_cnt = 4'h0;
            nxt_r.st      = ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (rise_c) begin
            nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
          end else if (fall_c) begin
            if (r_ff.bit_cnt == 4'h8) begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.st     = ST_RD_ACK;
            end else begin
              nxt_r.shreg  = {r_ff.shreg[6:0], 1'b0};
              nxt_r.sda_oe = ~r_ff.shreg[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (rise_c) begin
            nxt_r.nack = sda_s;
          end else if (fall_c) begin
            if (r_ff.nack) begin
              nxt_r.st = ST_IDLE;
            end else begin
              nxt_r.bit_cnt = 4'h0;
              nxt_r.shreg   = rd_data;
              nxt_r.sda_oe  = ~rd_data[7];
              nxt_r.ptr     = r_ff.ptr + 8'h01;
              nxt_r.st      = ST_RD_BYTE;
            end
          end
        end
        default: begin
          nxt_r.st     = ST_IDLE;
          nxt_r.sda_oe = 1'b0;
        end
      endcase
    end

    // Soft reset outranks a host write in the same cycle
    if (soft_reg_reset) begin
      nxt_r.ctl11 = ccs_ctl11_s'((r_ff.ctl11 & SOFT_KEEP_MASK_11) |
                                 (SENSE_TIMEOUT_RST & ~SOFT_KEEP_MASK_11));
      nxt_r.ctl12 = ccs_ctl12_s'((OUTPUT_PROTECT_RST & CTL12_WR_MASK) | {6'h00, role_s});
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      r_ff       <= '0;
      r_ff.ctl11 <= SENSE_TIMEOUT_RST;
      r_ff.ctl12 <= OUTPUT_PROTECT_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign sda_out             = r_ff.sda_low;
  assign sda_oe              = r_ff.sda_oe;
  assign fet_off             = r_ff.fet_off;
  assign charge_enable_clear = r_ff.chg_clr;
  assign watchdog_restart    = r_ff.wd_restart;
  assign cfg = '{sense_resistor_sel:        r_ff.ctl11.sense_resistor_sel,
                 softstart_limit:           r_ff.ctl11.softstart_limit,
                 undercurrent_deglitch_sel: r_ff.ctl11.undercurrent_deglitch_sel,
                 out_overvolt_off:          r_ff.ctl12.out_overvolt_off,
                 out_overvolt_level:        r_ff.ctl12.out_overvolt_level,
                 switch_freq_trim:          r_ff.ctl12.switch_freq_trim,
                 switch_freq_qkhz:          r_ff.freq};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_soft_sense_clear: assert property (soft_reg_reset |=>
    !cfg.sense_resistor_sel && cfg.undercurrent_deglitch_sel == 2'h0)
    else $error("sense or deglitch select not cleared by soft reset");

  a_soft_keeps_limit: assert property (soft_reg_reset |=>
    cfg.softstart_limit == $past(cfg.softstart_limit))
    else $error("soft-start code changed by soft reset");

  a_soft_ctl12_dflt: assert property (soft_reg_reset |=>
    r_ff.ctl12[7:2] == OUTPUT_PROTECT_RST[7:2])
    else $error("output protect control not restored by soft reset");

  a_ovp_fet_off: assert property (
    fault_s.out_overvolt_flag && !cfg.out_overvolt_off |=> fet_off)
    else $error("FETs not turned off on output overvoltage");

  a_ovp_chg_clear: assert property ($rose(fet_off) |-> charge_enable_clear
    ##1 !charge_enable_clear)
    else $error("charge enable clear pulse missing or stretched");

  a_ovp_disabled: assert property (cfg.out_overvolt_off |=> !fet_off)
    else $error("FETs turned off while protection disabled");

  a_freq_trim_up: assert property (
    cfg.switch_freq_trim == TRIM_UP |=>
    cfg.switch_freq_qkhz == $past(base_q) + $past(base_q) / TRIM_DIVISOR)
    else $error("raised switching frequency wrong");

  a_role_read_only: assert property (1'b1 |=> r_ff.ctl12.role_select == $past(role_s))
    else $error("role field does not follow strap");

  a_stat_live: assert property (1'b1 |=> stat13 == $past(fault_s[12:5]))
    else $error("battery and bus status not live");

  a_stat14_rsvd: assert property (stat14[3] == 1'b0 && stat14[1:0] == 2'h0
    && stat14[2] == r_ff.fault.flying_cap_short_flag)
    else $error("input status reserved bits not zero");

  a_wd_restart: assert property (soft_reg_reset |=> watchdog_restart ##1
    (watchdog_restart == $past(soft_reg_reset)))
    else $error("watchdog restart does not follow soft reset");

  // Protection path: the FETs follow the comparator only while it is enabled,
  // and the charge-enable clear is a single pulse on the way in
  a_ovp_release: assert property (!fault_s.out_overvolt_flag |=> !fet_off)
    else $error("FETs held off without output overvoltage");

  a_fet_needs_fault: assert property (fet_off |->
    $past(fault_s.out_overvolt_flag) && !$past(cfg.out_overvolt_off))
    else $error("FETs turned off without a cause");

  a_chg_only_rise: assert property (charge_enable_clear |-> fet_off && !$past(fet_off))
    else $error("charge enable clear outside a rise of FET off");

  a_soft_reserved: assert property (soft_reg_reset |=>
    r_ff.ctl11.reserved == SENSE_TIMEOUT_RST[1:0] && !r_ff.ctl12.reserved)
    else $error("reserved bits not restored by soft reset");

  a_freq_trim_down: assert property (
    cfg.switch_freq_trim == TRIM_DOWN |=>
    cfg.switch_freq_qkhz == $past(base_q) - $past(base_q) / TRIM_DIVISOR)
    else $error("lowered switching frequency wrong");

  a_freq_trim_none: assert property (
    cfg.switch_freq_trim != TRIM_UP && cfg.switch_freq_trim != TRIM_DOWN |=>
    cfg.switch_freq_qkhz == $past(base_q))
    else $error("untrimmed switching frequency wrong");

  a_freq_base_dflt: assert property (
    switch_freq_base == 3'h4 && cfg.switch_freq_trim == TRIM_NOMINAL |=>
    cfg.switch_freq_qkhz == FREQ_Q_500K)
    else $error("default base frequency wrong");

  a_stat14_live: assert property (1'b1 |=> stat14[7:4] == $past(fault_s[4:1]))
    else $error("input status not live");

  a_wd_quiet: assert property (!soft_reg_reset |=> !watchdog_restart)
    else $error("watchdog restart without soft reset");

endmodule : charger_control_status_regs

// [verification/ccs_host_model.sv]
// Host model that masters the two-wire register port
`timescale 1ns/1ps
module ccs_host_model (
  // Clock
  input  wire logic clock,
  // Bus lines, SDA pulled up, SCL driven by the host
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  import ccs_pkg::*;
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick
  // SCL stays low ten clocks so the synchronised slave can answer in time
  task automatic slot(input logic b, output logic r);
    tick(5);
    sda_low = !b;
    tick(5);
    scl = 1'b1;
    tick(5);
    r = sda;
    tick(5);
    scl = 1'b0;
  endtask : slot
  // Also serves as repeated start when SCL is low
  task automatic start();
    tick(5);
    sda_low = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(5);
    sda_low = 1'b1;
    tick(5);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(5);
    sda_low = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(5);
    sda_low = 1'b0;
    tick(10);
  endtask : stop
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      slot(tx[i], rx[i]);
    end
    slot(ack_in, ack);
  endtask : xfer
  task automatic write_regs(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d0,
                            input logic [7:0] d1, input int n, output logic ok);
    logic [7:0] rx;
    logic       ack;
    start();
    xfer({a, 1'b0}, 1'b1, rx, ack);
    ok = !ack;
    xfer(p, 1'b1, rx, ack);
    ok = ok & !ack;
    xfer(d0, 1'b1, rx, ack);
    ok = ok & !ack;
    if (n > 1) begin
      xfer(d1, 1'b1, rx, ack);
      ok = ok & !ack;
    end
    stop();
  endtask : write_regs
  // Pointer write, repeated start, one byte read with NACK
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] rx;
    logic       ack;
    start();
    xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, rx, ack);
    xfer(p, 1'b1, rx, ack);
    start();
    xfer({I2C_DEV_ADDR, 1'b1}, 1'b1, rx, ack);
    xfer(8'hff, 1'b1, d, ack);
    stop();
  endtask : read_reg
endmodule : ccs_host_model

// [verification/charger_control_status_regs_tb_top.sv]
// Self-checking bench for the charger control and status registers
`timescale 1ns/1ps
module charger_control_status_regs_tb_top;
  import ccs_pkg::*;
  logic       clock;
  logic       reset_n;
  logic       scl;
  logic       host_low;
  logic       sda_oe;
  logic       sda_out;
  logic       sda;
  logic       soft_reg_reset;
  logic [1:0] role_strap;
  logic [2:0] freq_base;
  logic       fet_off;
  logic       chg_clr;
  logic       wd_restart;
  ccs_fault_s fault_in;
  ccs_cfg_s   cfg;
  int         bad_count;
  int         samples_checked;
  int         cycles;
  // Open drain with pull-up: low if either party pulls
  assign sda = !(host_low | sda_oe);
  initial clock = 1'b0;
  always #10 clock = ~clock;
  ccs_host_model host (.clock(clock), .sda(sda), .scl(scl), .sda_low(host_low));
  charger_control_status_regs dut (
    .clock(clock), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .fault_in(fault_in), .role_strap(role_strap),
    .soft_reg_reset(soft_reg_reset), .switch_freq_base(freq_base), .cfg(cfg),
    .fet_off(fet_off), .charge_enable_clear(chg_clr), .watchdog_restart(wd_restart));
  task automatic summarize();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk8
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask : chk1
  task automatic chk12(input string n, input logic [11:0] e, input logic [11:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk12
  function automatic logic [7:0] exp13(input ccs_fault_s f);
    return f[12:5];
  endfunction : exp13
  function automatic logic [7:0] exp14(input ccs_fault_s f);
    return {f[4:1], 1'b0, f[0], 2'b00};
  endfunction : exp14
  function automatic logic [11:0] exp_freq(input logic [2:0] b, input logic [1:0] t);
    logic [11:0] q;
    case (b)
      3'h0: q = FREQ_Q_187K5;
      3'h1: q = FREQ_Q_250K;
      3'h2: q = FREQ_Q_300K;
      3'h3: q = FREQ_Q_375K;
      3'h5: q = FREQ_Q_750K;
      default: q = FREQ_Q_500K;
    endcase
    if (t == TRIM_UP) return q + q / TRIM_DIVISOR;
    if (t == TRIM_DOWN) return q - q / TRIM_DIVISOR;
    return q;
  endfunction : exp_freq
  // Hang guard, well above the length of the sequence
  always @(posedge clock) begin
    cycles++;
    if (cycles == 95000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    logic [7:0] d;
    logic [7:0] r;
    logic       ok;
    ccs_fault_s f;
    int         t;
    logic [2:0] fb;
    reset_n = 1'b0;
    soft_reg_reset = 1'b0;
    role_strap = 2'h0;
    freq_base = 3'h4;
    fault_in = '0;
    bad_count = 0;
    samples_checked = 0;
    cycles = 0;
    t = $urandom(32'hcc4f_c398);
    repeat (2) @(posedge clock);
    #2 reset_n = 1'b1;
    host.tick(4);
    host.read_reg(ADDR_SENSE_TIMEOUT_CONTROL, r);
    chk8("ctl11", SENSE_TIMEOUT_RST, r);
    host.read_reg(ADDR_OUTPUT_PROTECT_CONTROL, r);
    chk8("ctl12", OUTPUT_PROTECT_RST, r);
    host.read_reg(ADDR_BATTERY_BUS_FAULT_STAT, r);
    chk8("stat13", STATUS_RST, r);
    host.read_reg(ADDR_INPUT_CURRENT_FAULT_STAT, r);
    chk8("stat14", STATUS_RST, r);
    chk1("sda out", 1'b0, sda_out);
    // Two-byte writes cross from 0x11 into 0x12 by auto-increment
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hff : 8'($urandom);
      role_strap = 2'($urandom_range(2));
      host.write_regs(I2C_DEV_ADDR, ADDR_SENSE_TIMEOUT_CONTROL, d, ~d, 2, ok);
      chk1("ack", 1'b1, ok);
      host.read_reg(ADDR_SENSE_TIMEOUT_CONTROL, r);
      chk8("ctl11", d, r);
      host.read_reg(ADDR_OUTPUT_PROTECT_CONTROL, r);
      chk8("ctl12", {~d[7:2], role_strap}, r);
      chk8("cfg11", {d[7:2], 2'b00}, {cfg[22:17], 2'b00});
      chk8("cfg12", {~d[7:3], 3'b000}, {cfg[16:12], 3'b000});
    end
    for (int i = 0; i < 6; i++) begin
      f = (i == 0) ? '1 : ccs_fault_s'(13'($urandom));
      fault_in = f;
      host.write_regs(I2C_DEV_ADDR, ADDR_BATTERY_BUS_FAULT_STAT, ~exp13(f), ~exp14(f), 2, ok);
      host.read_reg(ADDR_BATTERY_BUS_FAULT_STAT, r);
      chk8("stat13", exp13(f), r);
      host.read_reg(ADDR_BATTERY_BUS_FAULT_STAT, r);
      chk8("stat13 again", exp13(f), r);
      host.read_reg(ADDR_INPUT_CURRENT_FAULT_STAT, r);
      chk8("stat14", exp14(f), r);
    end
    fault_in = '0;
    host.write_regs(I2C_DEV_ADDR, ADDR_SENSE_TIMEOUT_CONTROL, 8'hbe, 8'hfc, 2, ok);
    @(posedge clock);
    #2 soft_reg_reset = 1'b1;
    @(posedge clock);
    #2 soft_reg_reset = 1'b0;
    chk1("wd restart", 1'b1, wd_restart);
    host.tick(1);
    chk1("wd restart end", 1'b0, wd_restart);
    host.read_reg(ADDR_SENSE_TIMEOUT_CONTROL, r);
    chk8("ctl11 soft", 8'h31, r);
    host.read_reg(ADDR_OUTPUT_PROTECT_CONTROL, r);
    chk8("ctl12 soft", {6'b011000, role_strap}, r);
    host.write_regs(I2C_DEV_ADDR, ADDR_OUTPUT_PROTECT_CONTROL, 8'h60, 8'h00, 1, ok);
    fault_in.out_overvolt_flag = 1'b1;
    for (t = 0; t < 8 && fet_off !== 1'b1; t++) host.tick(1);
    chk1("fet off", 1'b1, fet_off);
    chk1("charge clear", 1'b1, chg_clr);
    chk1("fet delay", 1'b1, t == 3);
    host.tick(1);
    chk1("charge clear end", 1'b0, chg_clr);
    host.write_regs(I2C_DEV_ADDR, ADDR_OUTPUT_PROTECT_CONTROL, 8'he0, 8'h00, 1, ok);
    chk1("fet off disabled", 1'b0, fet_off);
    fault_in = '0;
    for (t = 0; t < 4; t++) begin
      fb = 3'($urandom);
      host.write_regs(I2C_DEV_ADDR, ADDR_OUTPUT_PROTECT_CONTROL, {3'b011, t[1:0], 3'b000},
                      8'h00, 1, ok);
      for (int i = 0; i < 8; i++) begin
        freq_base = i[2:0] ^ fb;
        host.tick(3);
        chk12("freq", exp_freq(i[2:0] ^ fb, t[1:0]), cfg.switch_freq_qkhz);
      end
    end
    host.write_regs(7'h15, ADDR_SENSE_TIMEOUT_CONTROL, 8'h00, 8'h00, 1, ok);
    chk1("foreign ack", 1'b0, ok);
    host.read_reg(8'h20, r);
    chk8("unmapped", 8'h00, r);
    host.read_reg(ADDR_SENSE_TIMEOUT_CONTROL, r);
    chk8("ctl11 kept", 8'h31, r);
    // Only a power-on reset brings the soft-start code back
    reset_n = 1'b0;
    host.tick(2);
    reset_n = 1'b1;
    host.tick(4);
    host.read_reg(ADDR_SENSE_TIMEOUT_CONTROL, r);
    chk8("ctl11 por", SENSE_TIMEOUT_RST, r);
    summarize();
  end
endmodule : charger_control_status_regs_tb_top
